// File: rfile_core.sv
// core register file: banks, bases, pc, stacks, flags
// assumes datapath and interrupt sequencer on aclk; software over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module rfile_core (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // datapath 16/20-bit write
    input wire logic core_wr_en,
    input wire rfile_pkg::rfile_sel_t core_wr_sel,
    input wire logic [19:0] core_wr_data,
    input wire logic [1:0] core_wr_byte,
    // datapath 32-bit pair write
    input wire rfile_pkg::rfile_pair_t core_wr32_sel,
    input wire logic [31:0] core_wr32_data,
    // datapath read
    input wire rfile_pkg::rfile_sel_t core_rd_sel,
    output logic [19:0] core_rd_data,
    // alu flag update: c, z, s, o
    input wire logic [3:0] alu_flag_we,
    input wire logic alu_carry,
    input wire logic alu_overflow,
    input wire logic [15:0] alu_result,
    input wire logic alu_byte,
    // interrupt sequencing
    input wire logic irq_req,
    input wire logic irq_maskable,
    input wire logic [2:0] irq_level,
    input wire logic irq_ack,
    input wire logic swi_exec,
    input wire logic [5:0] swi_num,
    output logic irq_accept,
    // registered views
    output logic [31:0] data_pair_low,
    output logic [31:0] data_pair_high,
    output logic [31:0] addr_pair,
    output logic [15:0] active_stack_ptr,
    output logic [15:0] frame_base,
    output logic [15:0] static_base,
    output logic [19:0] vector_table_base,
    output logic [19:0] program_counter,
    output logic [10:0] processor_flags
);
    import rfile_pkg::*;

    function automatic logic [15:0] merge16(
        input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    function automatic logic [19:0] merge20(
        input logic [19:0] old, input logic [19:0] nw, input logic [2:0] be);
        merge20 = {be[2] ? nw[19:16] : old[19:16], merge16(old[15:0], nw[15:0], be[1:0])};
    endfunction

    // storage; slots 0-3 data, 4-5 address, 6 frame base
    logic [15:0] bank_q [0:1][0:BANK_SLOTS-1];
    logic [15:0] user_sp;
    logic [15:0] irq_sp;
    logic [15:0] sb_q;
    logic [19:0] vtb_q;
    logic [19:0] pc_q;
    logic [10:0] flg_q;

    // axi state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_off;
    logic aw_hi_ok;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire bank = flg_q[FLG_B];
    wire sp_user = flg_q[FLG_U];
    wire [2:0] priority_level = flg_q[FLG_IPL +: 3];
    wire [15:0] sp_cur = sp_user ? user_sp : irq_sp;

    // axi write decode
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_bank0 = aw_off[7:5] == OFF_BANK0[7:5] && aw_off[4:2] != 3'd7;
    wire wr_bank1 = aw_off[7:5] == OFF_BANK1[7:5] && aw_off[4:2] != 3'd7;
    wire wr_bank_hit = aw_hi_ok && (wr_bank0 || wr_bank1);
    wire wr_bsel = wr_bank1;
    wire [2:0] wr_slot = aw_off[4:2];
    wire wr_vtb = aw_hi_ok && aw_off[7:2] == OFF_VTB[7:2];
    wire wr_vtb_up = aw_hi_ok && aw_off[7:2] == OFF_VTB_UP[7:2];
    wire wr_vtb_lo = aw_hi_ok && aw_off[7:2] == OFF_VTB_LO[7:2];
    wire wr_pc = aw_hi_ok && aw_off[7:2] == OFF_PC[7:2];
    wire wr_usp = aw_hi_ok && aw_off[7:2] == OFF_USP[7:2];
    wire wr_isp = aw_hi_ok && aw_off[7:2] == OFF_ISP[7:2];
    wire wr_sb = aw_hi_ok && aw_off[7:2] == OFF_SB[7:2];
    wire wr_flg = aw_hi_ok && aw_off[7:2] == OFF_FLG[7:2];
    wire wr_ro = aw_hi_ok && aw_off[7:4] == OFF_SP[7:4];
    wire wr_ok = wr_bank_hit || wr_vtb || wr_vtb_up || wr_vtb_lo || wr_pc
        || wr_usp || wr_isp || wr_sb || wr_flg || wr_ro;
    wire [15:0] wd16 = wdata_q[15:0];
    wire [19:0] wd20 = wdata_q[19:0];
    wire [1:0] be16 = wstrb_q[1:0];
    wire [2:0] be20 = wstrb_q[2:0];

    // core write decode
    wire core_bank = core_wr_en && core_wr_sel <= RFILE_SEL_FB;
    wire [2:0] core_slot = core_wr_sel[2:0];
    wire core_byte_ok = core_wr_sel == RFILE_SEL_D0 || core_wr_sel == RFILE_SEL_D1;
    wire [1:0] core_be = core_byte_ok ? core_wr_byte : 2'b11;
    wire core_usp = core_wr_en && (core_wr_sel == RFILE_SEL_USP
        || (core_wr_sel == RFILE_SEL_SP && sp_user));
    wire core_isp = core_wr_en && (core_wr_sel == RFILE_SEL_ISP
        || (core_wr_sel == RFILE_SEL_SP && !sp_user));
    wire core_sel_flg = core_wr_en && core_wr_sel == RFILE_SEL_FLG;

    // zero and sign from an 8- or 16-bit result
    wire res_zero = alu_byte ? alu_result[7:0] == 8'h00 : alu_result == 16'h0000;
    wire res_neg = alu_byte ? alu_result[7] : alu_result[15];
    wire swi_hw_range = swi_num <= 6'(SWI_HW_MAX);

    // banked registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int b = 0; b < 2; b++) begin
                for (int s = 0; s < BANK_SLOTS; s++) begin
                    bank_q[b][s] <= RST_REG16;
                end
            end
        end else begin
            if (wr_go && wr_bank_hit) begin
                bank_q[wr_bsel][wr_slot] <= merge16(bank_q[wr_bsel][wr_slot], wd16, be16);
            end
            if (core_bank) begin
                bank_q[bank][core_slot] <= merge16(bank_q[bank][core_slot],
                    core_wr_data[15:0], core_be);
            end
            case (core_wr32_sel)
                RFILE_PAIR_LOW: begin
                    bank_q[bank][2] <= core_wr32_data[31:16];
                    bank_q[bank][0] <= core_wr32_data[15:0];
                end
                RFILE_PAIR_HIGH: begin
                    bank_q[bank][3] <= core_wr32_data[31:16];
                    bank_q[bank][1] <= core_wr32_data[15:0];
                end
                RFILE_PAIR_ADDR: begin
                    bank_q[bank][5] <= core_wr32_data[31:16];
                    bank_q[bank][4] <= core_wr32_data[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // stacks, static base, vector table base, program counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            user_sp <= RST_REG16;
            irq_sp <= RST_REG16;
            sb_q <= RST_REG16;
            vtb_q <= RST_REG20;
            pc_q <= RST_REG20;
        end else begin
            if (wr_go && wr_usp) user_sp <= merge16(user_sp, wd16, be16);
            if (wr_go && wr_isp) irq_sp <= merge16(irq_sp, wd16, be16);
            if (wr_go && wr_sb) sb_q <= merge16(sb_q, wd16, be16);
            if (wr_go && wr_vtb) vtb_q <= merge20(vtb_q, wd20, be20);
            if (wr_go && wr_vtb_up && be16[0]) vtb_q[19:16] <= wd16[3:0];
            if (wr_go && wr_vtb_lo) vtb_q[15:0] <= merge16(vtb_q[15:0], wd16, be16);
            if (wr_go && wr_pc) pc_q <= merge20(pc_q, wd20, be20);
            if (core_usp) user_sp <= core_wr_data[15:0];
            if (core_isp) irq_sp <= core_wr_data[15:0];
            if (core_wr_en && core_wr_sel == RFILE_SEL_SB) sb_q <= core_wr_data[15:0];
            if (core_wr_en && core_wr_sel == RFILE_SEL_VTB) vtb_q <= core_wr_data;
            if (core_wr_en && core_wr_sel == RFILE_SEL_VTB_UP) begin
                vtb_q[19:16] <= core_wr_data[3:0];
            end
            if (core_wr_en && core_wr_sel == RFILE_SEL_VTB_LO) begin
                vtb_q[15:0] <= core_wr_data[15:0];
            end
            if (core_wr_en && core_wr_sel == RFILE_SEL_PC) pc_q <= core_wr_data;
        end
    end

    // flags; hardware updates land last and win over software writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flg_q <= RST_FLG;
        end else begin
            if (wr_go && wr_flg) begin
                flg_q <= 11'(merge16({5'h00, flg_q}, wd16, be16));
            end
            if (core_sel_flg) flg_q <= core_wr_data[10:0];
            if (alu_flag_we[0]) flg_q[FLG_C] <= alu_carry;
            if (alu_flag_we[1]) flg_q[FLG_Z] <= res_zero;
            if (alu_flag_we[2]) flg_q[FLG_S] <= res_neg;
            if (alu_flag_we[3]) flg_q[FLG_O] <= alu_overflow;
            if (irq_ack || swi_exec) flg_q[FLG_I] <= 1'b0;
            if (irq_ack || (swi_exec && swi_hw_range)) begin
                flg_q[FLG_U] <= 1'b0;
            end
        end
    end

    // software read mux
    wire [7:0] ar_off = s_axi_araddr[7:0];
    wire ar_hi_ok = s_axi_araddr[31:8] == 24'h000000;
    wire ar_b1 = ar_off[7:5] == OFF_BANK1[7:5];
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = 32'h00000000;
        rd_ok = ar_hi_ok;
        if (ar_off[7:6] == 2'b00 && ar_off[4:2] != 3'd7) begin
            rd_mux = {16'h0000, bank_q[ar_b1][ar_off[4:2]]};
        end else begin
            case (ar_off[7:2])
                OFF_VTB[7:2]: rd_mux = {12'h000, vtb_q};
                OFF_VTB_UP[7:2]: rd_mux = {28'h0000000, vtb_q[19:16]};
                OFF_VTB_LO[7:2]: rd_mux = {16'h0000, vtb_q[15:0]};
                OFF_PC[7:2]: rd_mux = {12'h000, pc_q};
                OFF_USP[7:2]: rd_mux = {16'h0000, user_sp};
                OFF_ISP[7:2]: rd_mux = {16'h0000, irq_sp};
                OFF_SB[7:2]: rd_mux = {16'h0000, sb_q};
                OFF_FLG[7:2]: rd_mux = {21'h000000, flg_q};
                OFF_SP[7:2]: rd_mux = {16'h0000, sp_cur};
                OFF_PAIR_LO[7:2]: rd_mux = {bank_q[bank][2], bank_q[bank][0]};
                OFF_PAIR_HI[7:2]: rd_mux = {bank_q[bank][3], bank_q[bank][1]};
                OFF_APAIR[7:2]: rd_mux = {bank_q[bank][5], bank_q[bank][4]};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // datapath read mux, current bank
    logic [19:0] core_mux;
    always_comb begin
        core_mux = 20'h00000;
        case (core_rd_sel)
            RFILE_SEL_D0, RFILE_SEL_D1, RFILE_SEL_D2, RFILE_SEL_D3,
            RFILE_SEL_A0, RFILE_SEL_A1, RFILE_SEL_FB:
                core_mux = {4'h0, bank_q[bank][core_rd_sel[2:0]]};
            RFILE_SEL_SB: core_mux = {4'h0, sb_q};
            RFILE_SEL_USP: core_mux = {4'h0, user_sp};
            RFILE_SEL_ISP: core_mux = {4'h0, irq_sp};
            RFILE_SEL_SP: core_mux = {4'h0, sp_cur};
            RFILE_SEL_VTB: core_mux = vtb_q;
            RFILE_SEL_VTB_UP: core_mux = {16'h0000, vtb_q[19:16]};
            RFILE_SEL_VTB_LO: core_mux = {4'h0, vtb_q[15:0]};
            RFILE_SEL_PC: core_mux = pc_q;
            RFILE_SEL_FLG: core_mux = {9'h000, flg_q};
            default: core_mux = 20'h00000;
        endcase
    end

    // interrupt acceptance
    wire prio_ok = irq_level > priority_level;
    wire mask_ok = !irq_maskable || flg_q[FLG_I];
    wire next_irq_accept = irq_req && prio_ok && mask_ok;

    // axi write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_off <= 8'h00;
            aw_hi_ok <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_off <= s_axi_awaddr[7:0];
                aw_hi_ok <= s_axi_awaddr[31:8] == 24'h000000;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire next_awready = !aw_held && !(s_axi_awvalid && s_axi_awready);
    wire next_wready = !w_held && !(s_axi_wvalid && s_axi_wready);

    // ready flops, read channel, registered views
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
            core_rd_data <= 20'h00000;
            irq_accept <= 1'b0;
            data_pair_low <= 32'h00000000;
            data_pair_high <= 32'h00000000;
            addr_pair <= 32'h00000000;
            active_stack_ptr <= RST_REG16;
        end else begin
            s_axi_awready <= next_awready && !wr_go;
            s_axi_wready <= next_wready && !wr_go;
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_ok ? rd_mux : 32'h00000000;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            core_rd_data <= core_mux;
            irq_accept <= next_irq_accept;
            data_pair_low <= {bank_q[bank][2], bank_q[bank][0]};
            data_pair_high <= {bank_q[bank][3], bank_q[bank][1]};
            addr_pair <= {bank_q[bank][5], bank_q[bank][4]};
            active_stack_ptr <= sp_cur;
        end
    end

    assign frame_base = bank_q[bank][SLOT_FB];
    assign static_base = sb_q;
    assign vector_table_base = vtb_q;
    assign program_counter = pc_q;
    assign processor_flags = flg_q;
endmodule // rfile_core
`default_nettype wire

// File: rfile_dp_model.sv
// partner model: datapath and interrupt sequencer
// assumes one task at a time; pulses last one aclk
`timescale 1ns/1ps
`default_nettype none
module rfile_dp_model (
    // clock
    input wire logic aclk,
    // datapath writes and alu
    output logic core_wr_en,
    output rfile_pkg::rfile_sel_t core_wr_sel,
    output logic [19:0] core_wr_data,
    output logic [1:0] core_wr_byte,
    output logic [3:0] alu_flag_we,
    output logic alu_carry,
    output logic alu_overflow,
    output logic [15:0] alu_result,
    // interrupt sequencing
    output logic irq_req,
    output logic irq_maskable,
    output logic [2:0] irq_level,
    output logic irq_ack,
    output logic swi_exec,
    output logic [5:0] swi_num
);
    import rfile_pkg::*;
    initial begin
        {core_wr_en, core_wr_data, core_wr_byte, alu_flag_we, alu_carry, alu_overflow} = '0;
        {alu_result, irq_req, irq_maskable, irq_level, irq_ack, swi_exec, swi_num} = '0;
        core_wr_sel = RFILE_SEL_D0;
    end
    task pulse_end();
        @(posedge aclk);
        {core_wr_en, alu_flag_we, irq_req, irq_ack, swi_exec} <= '0;
    endtask
    task core_write(input rfile_sel_t sel, input logic [19:0] d, input logic [1:0] be);
        @(posedge aclk);
        core_wr_en <= 1'b1;
        core_wr_sel <= sel;
        core_wr_data <= d;
        core_wr_byte <= be;
        pulse_end();
    endtask
    // add, debug flag untouched
    task alu_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        @(posedge aclk);
        alu_flag_we <= 4'hf;
        alu_result <= sum[15:0];
        alu_carry <= sum[16];
        alu_overflow <= (a[15] == b[15]) && (sum[15] != a[15]);
        pulse_end();
    endtask
    task irq(input logic [2:0] lvl, input logic msk);
        @(posedge aclk);
        irq_req <= 1'b1;
        irq_level <= lvl;
        irq_maskable <= msk;
        pulse_end();
    endtask
    task ack();
        @(posedge aclk);
        irq_ack <= 1'b1;
        pulse_end();
    endtask
    task swi(input logic [5:0] num);
        @(posedge aclk);
        swi_exec <= 1'b1;
        swi_num <= num;
        pulse_end();
    endtask
endmodule // rfile_dp_model
`default_nettype wire

// File: rfile_pkg.sv
// constants and types of the register file
// assumes one 200 MHz clock, AXI4-Lite access
// Behaviour
// - thirteen visible registers, banked data/address/frame-base counted once
// - data, address and frame base come in two banks chosen by bank flag
// - data registers are 16 bit; first two also written as byte halves
// - 32-bit data operands pair reg two over zero and three over one
// - address registers 16 bit; pair with register one as upper half
// - frame base and static base are 16-bit addressing bases
// - vector table base is 20 bits, start of the vector table
// - vector table base reachable as upper 4 bits and lower 16 bits
// - program counter is 20 bits, address of the next instruction
// - user and interrupt stack pointers are separate 16-bit registers
// - stack select flag 0 picks interrupt pointer, 1 picks user pointer
// - stack select cleared on hardware acknowledge or software interrupt 0..31
// - flag register is 11 bits holding all processor state bits
// - carry flag loads the alu carry, borrow or shifted-out bit
// - zero flag is 1 for a zero result, else 0
// - sign flag is 1 for a negative result, else 0
// - overflow flag is 1 on overflow, else 0
// - maskable interrupts blocked while enable flag is 0
// - interrupt enable flag cleared whenever an interrupt is acknowledged
// - 3-bit priority level; request accepted only if strictly higher
// - reserved flag bit reads undefined; software writes it as 0
package rfile_pkg;
    localparam int FLG_C = 0;
    localparam int FLG_D = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int FLG_B = 4;
    localparam int FLG_O = 5;
    localparam int FLG_I = 6;
    localparam int FLG_U = 7;
    localparam int FLG_IPL = 8;
    localparam int FLG_W = 11;
    localparam int VTB_W = 20;
    localparam int PC_W = 20;
    localparam int SWI_HW_MAX = 31;
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [19:0] RST_REG20 = 20'h00000;
    localparam logic [10:0] RST_FLG = 11'h000;
    // word offsets, byte address bits 7:0
    localparam logic [7:0] OFF_BANK0 = 8'h00;
    localparam logic [7:0] OFF_BANK1 = 8'h20;
    localparam logic [7:0] OFF_VTB = 8'h40;
    localparam logic [7:0] OFF_VTB_UP = 8'h44;
    localparam logic [7:0] OFF_VTB_LO = 8'h48;
    localparam logic [7:0] OFF_PC = 8'h4c;
    localparam logic [7:0] OFF_USP = 8'h50;
    localparam logic [7:0] OFF_ISP = 8'h54;
    localparam logic [7:0] OFF_SB = 8'h58;
    localparam logic [7:0] OFF_FLG = 8'h5c;
    localparam logic [7:0] OFF_SP = 8'h60;
    localparam logic [7:0] OFF_PAIR_LO = 8'h64;
    localparam logic [7:0] OFF_PAIR_HI = 8'h68;
    localparam logic [7:0] OFF_APAIR = 8'h6c;
    localparam int BANK_SLOTS = 7;
    localparam int SLOT_FB = 6;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [3:0] {
        RFILE_SEL_D0, RFILE_SEL_D1, RFILE_SEL_D2, RFILE_SEL_D3,
        RFILE_SEL_A0, RFILE_SEL_A1, RFILE_SEL_FB, RFILE_SEL_SB,
        RFILE_SEL_USP, RFILE_SEL_ISP, RFILE_SEL_SP, RFILE_SEL_VTB,
        RFILE_SEL_VTB_UP, RFILE_SEL_VTB_LO, RFILE_SEL_PC, RFILE_SEL_FLG
    } rfile_sel_t;
    typedef enum logic [1:0] {
        RFILE_PAIR_LOW, RFILE_PAIR_HIGH, RFILE_PAIR_ADDR, RFILE_PAIR_NONE
    } rfile_pair_t;
endpackage

// File: rfile_properties.sv
// checker: flags, interrupt accept, read hold
// assumes rfile_core ports, rfile_pkg flag layout
`timescale 1ns/1ps
`default_nettype none
module rfile_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // alu side
    input wire logic [3:0] alu_flag_we,
    input wire logic alu_carry,
    input wire logic alu_overflow,
    input wire logic [15:0] alu_result,
    input wire logic alu_byte,
    // interrupt side
    input wire logic irq_req,
    input wire logic irq_maskable,
    input wire logic [2:0] irq_level,
    input wire logic irq_ack,
    input wire logic swi_exec,
    input wire logic [5:0] swi_num,
    input wire logic irq_accept,
    input wire logic [10:0] processor_flags,
    // read channel
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import rfile_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_low_swi;
        swi_exec && swi_num <= 6'd31;
    endsequence
    AST_ACK_CLEARS: assert property (
        irq_ack |=> !processor_flags[FLG_I] && !processor_flags[FLG_U])
        else $error("ack clear");
    AST_SWI_LOW: assert property (
        s_low_swi |=> !processor_flags[FLG_U] && !processor_flags[FLG_I])
        else $error("swi clear");
    AST_ACCEPT: assert property (
        1'b1 |=> irq_accept == ($past(irq_req) && $past(irq_level) > $past(processor_flags[10:8])
            && (!$past(irq_maskable) || $past(processor_flags[FLG_I]))))
        else $error("accept");
    AST_CARRY: assert property (
        alu_flag_we[0] |=> processor_flags[FLG_C] == $past(alu_carry))
        else $error("carry");
    AST_ZERO: assert property (
        alu_flag_we[1] && !alu_byte |=> processor_flags[FLG_Z] == ($past(alu_result) == 16'h0000))
        else $error("zero");
    AST_SIGN: assert property (
        alu_flag_we[2] && !alu_byte |=> processor_flags[FLG_S] == $past(alu_result[15]))
        else $error("sign");
    AST_OVERFLOW: assert property (
        alu_flag_we[3] |=> processor_flags[FLG_O] == $past(alu_overflow))
        else $error("overflow");
    AST_RHOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read hold");
endmodule // rfile_props
bind rfile_core rfile_props u_props (.*);
`default_nettype wire

// File: rfile_tb.sv
// testbench: AXI4-Lite and core-side tests
// assumes rfile_core, rfile_dp_model, bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rfile_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} rfile_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, core_wr32_data;
    logic [31:0] data_pair_low, data_pair_high, addr_pair;
    logic [3:0] s_axi_wstrb, alu_flag_we;
    logic [1:0] s_axi_bresp, s_axi_rresp, core_wr_byte, r;
    logic core_wr_en, alu_carry, alu_overflow, alu_byte, irq_req, irq_maskable, irq_ack;
    logic swi_exec, irq_accept;
    logic [2:0] irq_level;
    logic [5:0] swi_num;
    logic [15:0] alu_result, active_stack_ptr, frame_base, static_base;
    logic [19:0] core_wr_data, core_rd_data, vector_table_base, program_counter;
    logic [10:0] processor_flags;
    rfile_sel_t core_wr_sel, core_rd_sel;
    rfile_pair_t core_wr32_sel;
    int fails, comparisons;
    rfile_row_t rows[14] = '{'{8'h00, 32'hffffffff, 32'hffff},
        '{8'h08, 32'h12345678, 32'h5678}, '{8'h10, 32'ha0a, 32'ha0a}, '{8'h14, 32'hb0b, 32'hb0b},
        '{8'h20, 32'h5555, 32'h5555}, '{8'h28, 32'haaaa, 32'haaaa},
        '{8'h40, 32'hffffffff, 32'hfffff}, '{8'h44, 32'hffffffff, 32'hf},
        '{8'h48, 32'habcd, 32'habcd}, '{8'h4c, 32'hffffffff, 32'hfffff},
        '{8'h50, 32'hffffffff, 32'hffff}, '{8'h54, 32'h1111, 32'h1111},
        '{8'h58, 32'hffffffff, 32'hffff}, '{8'h5c, 32'hffd, 32'h7fd}};
    rfile_core uut (.*);
    rfile_dp_model dp (.*);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict(input bit hung);
        fails += hung;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        for (int n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
            if (n == 39) give_verdict(1);
        end
    endtask
    task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        for (int n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                {d, resp} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                break;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
            if (n == 39) give_verdict(1);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr({24'h0, a}, d, r);
        chk("bresp", 32'(r), 32'(RESP_OKAY));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        axi_rd({24'h0, a}, d, r);
        chk($sformatf("read %h", a), d, e);
        chk("rresp", 32'(r), 32'(RESP_OKAY));
    endtask
    task irq_chk(input logic [2:0] lvl, input logic msk, input logic e);
        dp.irq(lvl, msk);
        #1;
        chk("irq_accept", 32'(irq_accept), 32'(e));
    endtask
    task flag_chk(input logic [10:0] e);
        #1;
        chk("processor_flags", 32'(processor_flags), 32'(e));
    endtask
    initial begin
        logic [31:0] d;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, alu_byte, core_wr32_data, aresetn} = '0;
        {s_axi_wstrb, core_rd_sel, core_wr32_sel} = {4'hf, RFILE_SEL_D0, RFILE_PAIR_NONE};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h5c, 32'h0);
        rd(8'h4c, 32'h0);
        $display("reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        $display("table done");
        rd(8'h40, 32'hfabcd);
        rd(8'h64, 32'haaaa5555);
        rd(8'h60, 32'hffff);
        wr(8'h5c, 32'h0);
        rd(8'h64, 32'h5678ffff);
        rd(8'h68, 32'h0);
        rd(8'h6c, 32'hb0b0a0a);
        chk("data_pair_low", data_pair_low, 32'h5678ffff);
        rd(8'h60, 32'h1111);
        $display("banks done");
        axi_wr(32'h100, 32'h1, r);
        chk("bresp unmapped", 32'(r), 32'(RESP_SLVERR));
        axi_rd(32'h70, d, r);
        chk("rresp unmapped", {d[29:0], r}, 32'(RESP_SLVERR));
        wr(8'h60, 32'hffffffff);
        rd(8'h60, 32'h1111);
        dp.core_write(RFILE_SEL_D0, 20'h01200, 2'b10);
        rd(8'h00, 32'h12ff);
        $display("refusals done");
        wr(8'h5c, 32'h3c0);
        irq_chk(3'd3, 1'b1, 1'b0);
        irq_chk(3'd4, 1'b1, 1'b1);
        dp.ack();
        flag_chk(11'h300);
        irq_chk(3'd7, 1'b1, 1'b0);
        irq_chk(3'd7, 1'b0, 1'b1);
        irq_chk(3'd3, 1'b0, 1'b0);
        wr(8'h5c, 32'h3c0);
        dp.swi(6'd32);
        flag_chk(11'h380);
        dp.swi(6'd31);
        flag_chk(11'h300);
        $display("interrupts done");
        dp.alu_add(16'h7fff, 16'h0001);
        flag_chk(11'h328);
        dp.alu_add(16'hffff, 16'h0001);
        flag_chk(11'h305);
        core_wr32_data <= 32'h13572468;
        core_wr32_sel <= RFILE_PAIR_HIGH;
        @(posedge aclk);
        core_wr32_sel <= RFILE_PAIR_NONE;
        rd(8'h68, 32'h13572468);
        chk("core_rd_data", 32'(core_rd_data), 32'h12ff);
        $display("core side done");
        give_verdict(0);
    end
endmodule // testbench
`default_nettype wire
